// ---- emac_gpr_file.v ----
// emac_gpr_file.v: eight-entry general register file with registered reads
// assumes one write port and three read ports on the core clock
module emac_gpr_file #(
  parameter DW = 32,
  parameter AW = 3
) (
  input  wire          i_sys_clk,
  input  wire          i_rst,
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [DW-1:0] i_wdata,
  input  wire [AW-1:0] i_ra0,
  input  wire [AW-1:0] i_ra1,
  input  wire [AW-1:0] i_ra2,
  output reg  [DW-1:0] o_rd0,
  output reg  [DW-1:0] o_rd1,
  output reg  [DW-1:0] o_rd2
);
  `include "emac_map.vh"
  reg [DW-1:0] mem_q [0:(1<<AW)-1];  // storage words
  integer k;
  // write and registered reads; reset clears every entry
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (k = 0; k < (1<<AW); k = k + 1)
        mem_q[k] <= `EMAC_GPR_RST;
      o_rd0 <= `EMAC_GPR_RST;
      o_rd1 <= `EMAC_GPR_RST;
      o_rd2 <= `EMAC_GPR_RST;
    end
    else
    begin
      if (i_we)
        mem_q[i_waddr] <= i_wdata;
      o_rd0 <= mem_q[i_ra0];
      o_rd1 <= mem_q[i_ra1];
      o_rd2 <= mem_q[i_ra2];
    end
  end
endmodule // emac_gpr_file

// ---- emac_map.vh ----
// emac_map.vh: constants for the execution mode and address control block
// assumes inclusion by bare name from emac design files; definitions only
`ifndef EMAC_MAP_VH
`define EMAC_MAP_VH
// mode encodings (one-hot)
`define EMAC_MODE_REAL      3'h1
`define EMAC_MODE_PROT      3'h2
`define EMAC_MODE_SMM       3'h4
// offset limits
`define EMAC_LIM16          32'h0000FFFF
`define EMAC_LIM32          32'hFFFFFFFF
// real-mode linear space width (two to the twentieth bytes)
`define EMAC_REAL_AW        5'h14
// segment table size
`define EMAC_MAX_SEGS       14'h3FFF
// general register indices
`define EMAC_R_ACC          3'h0
`define EMAC_R_CNT          3'h1
`define EMAC_R_IOP          3'h2
`define EMAC_R_BASE         3'h3
`define EMAC_R_STK          3'h4
`define EMAC_R_FRM          3'h5
`define EMAC_R_SRC          3'h6
`define EMAC_R_DST          3'h7
// segment register indices (data segment index 3)
`define EMAC_SEG_DATA       3'h3
`define EMAC_NUM_SEGS       3'h6
// reset values
`define EMAC_GPR_RST        32'h00000000
`define EMAC_SEL_RST        16'h0000
`endif

// ---- emac_mode_ctrl.v ----
// emac_mode_ctrl.v: operating mode, address/operand size, address forming
// assumes a core that presents one instruction per boundary strobe
// Function
// - reset enters real-address mode
// - management irq pin or controller enters management mode
// - save context, switch to management memory
// - return restores exact pre-interrupt state; code restores only mode, default size and selectors, not general registers
// - byte addresses span zero to 4G-1
// - segmented model: selector plus offset to linear
// - real model: 64K segments, 2^20 space
// - real mode supports only real model
// - management memory uses real-like addressing
// - 32-bit size allows full 32-bit offsets in protected mode
// - 16-bit size limits offsets to FFFFH
// - logical address: 16-bit selector plus offset
// - prefixes override sizes for one instruction
// - protected default sizes from code descriptor
// - real mode 16-bit, override keeps FFFFH limit
// - eight 32-bit general registers
// - string ops use count, source, destination
// - base pointer offsets within data segment
// - at most six segment selectors held
// - virtual-8086 is a per-task attribute
// - each task may use its own model
// - accumulator holds implicit operands and results
module emac_mode_ctrl #(
  parameter DW = 32
) (
  input  wire          i_sys_clk,
  input  wire          i_rst,
  input  wire          i_sys_mgmt_irq_pin_n, // external pin, active low
  input  wire          i_local_irq_controller_smi, // pulse from controller
  input  wire          i_insn_boundary,      // one instruction retires
  input  wire          i_go_protected,       // request protected mode
  input  wire          i_smm_return,         // management handler returns
  input  wire          i_cs_default32,       // code descriptor default size
  input  wire          i_task_v86,           // current task v86 attribute
  input  wire          i_task_flat,          // current task flat model
  input  wire          i_pfx_addr,           // address-size prefix
  input  wire          i_pfx_opnd,           // operand-size prefix
  input  wire [2:0]    i_seg_sel,            // segment register index
  input  wire [15:0]   i_seg_wdata,          // selector to load
  input  wire          i_seg_we,             // load selector
  input  wire [31:0]   i_seg_base,           // base of selected segment
  input  wire [DW-1:0] i_offset,             // effective offset
  input  wire          i_use_base_ptr,       // offset from base pointer reg
  input  wire          i_gpr_we,             // write general register
  input  wire [2:0]    i_gpr_waddr,
  input  wire [DW-1:0] i_gpr_wdata,
  input  wire [2:0]    i_gpr_raddr,
  output reg  [2:0]    o_mode,               // one-hot operating mode
  output reg           o_addr32,             // effective address size 32
  output reg           o_opnd32,             // effective operand size 32
  output reg           o_sys_mgmt_memory_sel,// accesses go to mgmt memory
  output reg  [31:0]   o_linear_addr,        // formed linear address
  output reg  [47:0]   o_logical_addr,       // selector:offset
  output reg           o_limit_fault,        // offset beyond limit
  output reg           o_ctx_saved,          // context snapshot valid
  output wire [DW-1:0] o_gpr_rdata,
  output wire [DW-1:0] o_count_reg,
  output wire [DW-1:0] o_source_index_reg,
  output wire [DW-1:0] o_dest_index_reg
);
  `include "emac_map.vh"

  localparam [2:0] ST_REAL = `EMAC_MODE_REAL;
  localparam [2:0] ST_PROT = `EMAC_MODE_PROT;
  localparam [2:0] ST_SMM  = `EMAC_MODE_SMM;

  // offset limit for a given size and mode
  function [31:0] lim_of;
    input        a32;
    input [2:0]  md;
    begin
      if (md != ST_PROT)
        lim_of = `EMAC_LIM16;
      else if (a32)
        lim_of = `EMAC_LIM32;
      else
        lim_of = `EMAC_LIM16;
    end
  endfunction

  // pin synchroniser; the first stage is read only by the second
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_prev_q;                        // for falling edge detect
  reg smi_pend_q;                        // latched management request
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1_q   <= 1'b1;
      pin_s2_q   <= 1'b1;
      pin_prev_q <= 1'b1;
    end
    else
    begin
      pin_s1_q   <= i_sys_mgmt_irq_pin_n;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  wire smi_evt = (~pin_s2_q & pin_prev_q) | i_local_irq_controller_smi;

  // saved context: mode, default size, selectors
  reg  [2:0]  mode_q;
  reg         def32_q;
  reg  [2:0]  sv_mode_q;
  reg         ctx_q;                     // snapshot held; shown a cycle later
  reg         sv_def32_q;
  reg  [15:0] sel_q [0:5];               // six selectors only
  reg  [15:0] sv_sel_q [0:5];
  wire take_smi = i_insn_boundary & smi_pend_q & (mode_q != ST_SMM);

  // pending request: a new event wins over the clear when taken
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      smi_pend_q <= 1'b0;
    else if (smi_evt)
      smi_pend_q <= 1'b1;
    else if (take_smi)
      smi_pend_q <= 1'b0;
  end

  // mode machine; every change waits for an instruction boundary
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode_q     <= ST_REAL;
      def32_q    <= 1'b0;
      sv_mode_q  <= ST_REAL;
      sv_def32_q <= 1'b0;
      ctx_q      <= 1'b0;
    end
    else if (i_insn_boundary)
    begin
      case (mode_q)
        ST_REAL, ST_PROT:
        begin
          if (take_smi)
          begin
            sv_mode_q   <= mode_q;
            sv_def32_q  <= def32_q;
            ctx_q       <= 1'b1;
            mode_q      <= ST_SMM;
            def32_q     <= 1'b0;
          end
          else if (mode_q == ST_REAL && i_go_protected)
          begin
            mode_q  <= ST_PROT;
            def32_q <= i_cs_default32;
          end
          else if (mode_q == ST_PROT)
            def32_q <= i_cs_default32;
        end
        ST_SMM:
        begin
          if (i_smm_return)
          begin
            mode_q      <= sv_mode_q;
            def32_q     <= sv_def32_q;
            ctx_q       <= 1'b0;
          end
        end
        default:
          mode_q <= ST_REAL;
      endcase
    end
  end

  // selectors: loaded on request, snapshot on entry, restored on return
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_seg
      always @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          sel_q[g]    <= `EMAC_SEL_RST;
          sv_sel_q[g] <= `EMAC_SEL_RST;
        end
        else if (i_insn_boundary && take_smi)
          sv_sel_q[g] <= sel_q[g];
        else if (i_insn_boundary && mode_q == ST_SMM && i_smm_return)
          sel_q[g] <= sv_sel_q[g];
        else if (i_seg_we && i_seg_sel == g)
          sel_q[g] <= i_seg_wdata;
      end
    end
  endgenerate

  // effective sizes: prefix flips default for this instruction only
  reg        a32_d;
  reg        o32_d;
  reg [2:0]  seg_idx;
  reg [31:0] lim_d;
  reg [31:0] off_d;
  reg [31:0] lin_d;
  always @*
  begin
    a32_d = def32_q ^ i_pfx_addr;
    o32_d = def32_q ^ i_pfx_opnd;
    seg_idx = i_use_base_ptr ? `EMAC_SEG_DATA : i_seg_sel;
    if (seg_idx > 3'h5)
      seg_idx = `EMAC_SEG_DATA;          // only six exist
    lim_d = lim_of(a32_d, mode_q);
    off_d = a32_d ? i_offset : {16'h0000, i_offset[15:0]};
    if (mode_q == ST_PROT && !i_task_v86)
      lin_d = i_task_flat ? off_d : i_seg_base + off_d;
    else
      // real, v86 and management: selector shifted by four
      lin_d = {12'h000, ({4'h0, sel_q[seg_idx]} << 4) + {4'h0, off_d[15:0]}};
  end

  // registered address outputs
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_mode <= ST_REAL;
      o_addr32 <= 1'b0;
      o_opnd32 <= 1'b0;
      o_sys_mgmt_memory_sel <= 1'b0;
      o_linear_addr <= 32'h00000000;
      o_logical_addr <= 48'h000000000000;
      o_limit_fault <= 1'b0;
      o_ctx_saved <= 1'b0;
    end
    else
    begin
      o_mode <= mode_q;
      o_addr32 <= a32_d;
      o_opnd32 <= o32_d;
      o_sys_mgmt_memory_sel <= (mode_q == ST_SMM);
      // registered alongside the mode so both flags move on one edge
      o_ctx_saved <= ctx_q;
      o_linear_addr <= lin_d;
      o_logical_addr <= {sel_q[seg_idx], off_d};
      o_limit_fault <= (i_offset > lim_d);
    end
  end

  // general registers; fixed roles read out for string use: count and source
  wire [DW-1:0] rd_cnt;
  wire [DW-1:0] rd_src;
  emac_gpr_file #(.DW(DW), .AW(3)) u_gpr (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_we      (i_gpr_we),
    .i_waddr   (i_gpr_waddr),
    .i_wdata   (i_gpr_wdata),
    .i_ra0     (i_gpr_raddr),
    .i_ra1     (`EMAC_R_CNT),
    .i_ra2     (`EMAC_R_SRC),
    .o_rd0     (o_gpr_rdata),
    .o_rd1     (rd_cnt),
    .o_rd2     (rd_src)
  );
  // destination index kept as a shadow copy to avoid a fourth read port
  reg [DW-1:0] dst_q;
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      dst_q <= `EMAC_GPR_RST;
    else if (i_gpr_we && i_gpr_waddr == `EMAC_R_DST)
      dst_q <= i_gpr_wdata;
  end
  assign o_count_reg        = rd_cnt;
  assign o_source_index_reg = rd_src;
  assign o_dest_index_reg   = dst_q;
endmodule // emac_mode_ctrl

// ---- emac_mode_ctrl_sva.sv ----
// emac_mode_ctrl_sva.sv: port-level checker for the mode and address control block
// assumes emac_map.vh on the include path and a single core clock domain
`include "emac_map.vh"
module emac_mode_ctrl_sva #(
  parameter DW = 32
) (
  input logic          i_sys_clk,
  input logic          i_rst,
  input logic          i_local_irq_controller_smi,
  input logic          i_insn_boundary,
  input logic          i_smm_return,
  input logic [DW-1:0] i_offset,
  input logic          i_gpr_we,
  input logic [2:0]    i_gpr_waddr,
  input logic [DW-1:0] i_gpr_wdata,
  input logic [2:0]    o_mode,
  input logic          o_addr32,
  input logic          o_sys_mgmt_memory_sel,
  input logic [47:0]   o_logical_addr,
  input logic          o_limit_fault,
  input logic          o_ctx_saved,
  input logic [DW-1:0] o_dest_index_reg
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [2:0] pre_q; // last mode shown before management entry
  // remember where a return must land; frozen while management mode shows
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      pre_q <= `EMAC_MODE_REAL;
    else if (o_mode != `EMAC_MODE_SMM)
      pre_q <= o_mode;
  a_reset_real: assert property (
    $fell(i_rst) |=> o_mode == `EMAC_MODE_REAL) else $error("not real after reset");
  a_ctrl_entry: assert property (
    o_mode == `EMAC_MODE_REAL && i_local_irq_controller_smi ##1 i_insn_boundary && !i_smm_return
    |-> ##[1:3] o_mode == `EMAC_MODE_SMM) else $error("controller request not taken");
  a_mgmt_ctx: assert property (
    !$past(i_rst) |-> o_sys_mgmt_memory_sel == (o_mode == `EMAC_MODE_SMM)
    && o_ctx_saved == o_sys_mgmt_memory_sel) else $error("mgmt select mismatch");
  a_return_prior: assert property (
    o_mode == `EMAC_MODE_SMM && i_insn_boundary && i_smm_return
    |-> ##[1:3] o_mode == pre_q) else $error("return mode wrong");
  a_mode_boundary: assert property (
    !$past(i_rst, 2) && o_mode != $past(o_mode) |-> $past(i_insn_boundary, 2))
    else $error("mode moved off boundary");
  a_limit_real: assert property (
    !$past(i_rst) && o_mode != `EMAC_MODE_PROT
    |-> o_limit_fault == ($past(i_offset) > `EMAC_LIM16)) else $error("limit flag wrong");
  a_logical_16: assert property (
    !o_addr32 |-> o_logical_addr[31:16] == 16'h0000) else $error("offset not 16 bits");
  a_dest_shadow: assert property (
    i_gpr_we && i_gpr_waddr == `EMAC_R_DST |=> o_dest_index_reg == $past(i_gpr_wdata))
    else $error("dest index stale");
endmodule // emac_mode_ctrl_sva
bind emac_mode_ctrl emac_mode_ctrl_sva #(.DW(DW)) emac_mode_ctrl_sva_inst (.*);

// ---- emac_mode_ctrl_tb.sv ----
// emac_mode_ctrl_tb.sv: directed bench for the mode and address control block
// assumes emac_map.vh and the checker file compile alongside the design
`include "emac_map.vh"
module emac_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [2:0] M_R = `EMAC_MODE_REAL, M_P = `EMAC_MODE_PROT, M_S = `EMAC_MODE_SMM;
  logic i_sys_clk = 0, i_rst = 1, i_sys_mgmt_irq_pin_n = 1, i_local_irq_controller_smi = 0;
  logic i_insn_boundary = 0, i_go_protected = 0, i_smm_return = 0, i_cs_default32 = 0;
  logic i_task_v86 = 0, i_task_flat = 0, i_pfx_addr = 0, i_pfx_opnd = 0, i_seg_we = 0;
  logic i_use_base_ptr = 0, i_gpr_we = 0;
  logic [2:0] i_seg_sel = 0, i_gpr_waddr = 0, i_gpr_raddr = 0;
  logic [15:0] i_seg_wdata = 0;
  logic [31:0] i_seg_base = 0, i_offset = 0, i_gpr_wdata = 0;
  logic [2:0] o_mode;
  logic o_addr32, o_opnd32, o_sys_mgmt_memory_sel, o_limit_fault, o_ctx_saved;
  logic [31:0] o_linear_addr, o_gpr_rdata, o_count_reg, o_source_index_reg, o_dest_index_reg;
  logic [47:0] o_logical_addr;
  int err_total = 0;
  int n_checks = 0;
  int k;
  emac_mode_ctrl emac_mode_ctrl_inst (.*);
  always #5 i_sys_clk = ~i_sys_clk;
  // one compare; four-state so an unknown never matches
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // step past n edges, then drive just after the last one
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // one boundary strobe, then room for the one-cycle output lag
  task bnd;
    i_insn_boundary = 1;
    cyc(1);
    i_insn_boundary = 0;
    cyc(3);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task t_reset;
    i_rst = 1;
    cyc(3);
    i_rst = 0;
    cyc(3);
    chk("mode", o_mode, M_R);
    chk("cnt", o_count_reg, 0);
  endtask
  // data selector 1234, offset above the 16-bit limit, flat ignored in real mode
  task t_real;
    i_seg_sel = `EMAC_SEG_DATA;
    i_seg_wdata = 16'h1234;
    i_seg_we = 1;
    cyc(1);
    i_seg_we = 0;
    i_seg_sel = 0;
    i_use_base_ptr = 1;
    i_task_flat = 1;
    i_offset = 32'h0001ABCD;
    cyc(3);
    chk("lin", o_linear_addr, 32'h0001CF0D);
    chk("log", o_logical_addr, 48'h12340000ABCD);
    i_pfx_addr = 1;
    i_pfx_opnd = 1;
    cyc(2);
    chk("a32", o_addr32, 1);
    chk("o32", o_opnd32, 1);
    chk("flt", o_limit_fault, 1);
    i_pfx_addr = 0;
    i_pfx_opnd = 0;
    i_task_flat = 0;
    i_offset = 32'h00000010;
    cyc(2);
  endtask
  // controller request wins over a protected switch at the same boundary
  task t_smm_ctrl;
    i_local_irq_controller_smi = 1;
    cyc(1);
    i_local_irq_controller_smi = 0;
    i_go_protected = 1;
    bnd;
    i_go_protected = 0;
    chk("mode", o_mode, M_S);
    chk("ctx", o_ctx_saved, 1);
    chk("mem", o_sys_mgmt_memory_sel, 1);
    chk("lin", o_linear_addr, 32'h00012350);
    i_local_irq_controller_smi = 1;
    cyc(1);
    i_local_irq_controller_smi = 0;
    i_smm_return = 1;
    bnd;
    i_smm_return = 0;
    chk("mode", o_mode, M_R);
    bnd;
    chk("mode", o_mode, M_S);
    i_smm_return = 1;
    bnd;
    i_smm_return = 0;
  endtask
  task t_prot;
    i_go_protected = 1;
    i_cs_default32 = 1;
    bnd;
    i_go_protected = 0;
    bnd;
    chk("mode", o_mode, M_P);
    chk("a32", o_addr32, 1);
    i_use_base_ptr = 0;
    i_seg_base = 32'h00001000;
    i_offset = 32'h80000000;
    cyc(2);
    chk("lin", o_linear_addr, 32'h80001000);
    chk("flt", o_limit_fault, 0);
    chk("log", o_logical_addr, 48'h000080000000);
    i_task_flat = 1;
    i_pfx_addr = 1;
    cyc(2);
    chk("lin", o_linear_addr, 32'h00000000);
    chk("flt", o_limit_fault, 1);
    i_task_flat = 0;
    i_pfx_addr = 0;
    i_task_v86 = 1;
    i_use_base_ptr = 1;
    i_offset = 32'h00000010;
    cyc(2);
    chk("v86", o_linear_addr, 32'h00012350);
    i_task_v86 = 0;
  endtask
  // pin held low with boundaries back to back until entry, under a bound
  task t_smm_pin;
    i_sys_mgmt_irq_pin_n = 0;
    i_insn_boundary = 1;
    for (k = 0; k < 20 && o_mode !== M_S; k++)
      cyc(1);
    i_insn_boundary = 0;
    i_sys_mgmt_irq_pin_n = 1;
    chk("pin", o_mode, M_S);
    if (k == 20)
      report_and_stop;
    i_smm_return = 1;
    bnd;
    i_smm_return = 0;
    chk("mode", o_mode, M_P);
    chk("a32", o_addr32, 1);
  endtask
  // fill all eight registers, read each back, then the implicit ones
  task t_gpr;
    for (k = 0; k < 8; k++)
    begin
      i_gpr_we = 1;
      i_gpr_waddr = k[2:0];
      i_gpr_wdata = 32'h11111111 * (k + 1);
      cyc(1);
    end
    i_gpr_we = 0;
    for (k = 0; k < 8; k++)
    begin
      i_gpr_raddr = k[2:0];
      cyc(2);
      chk("gpr", o_gpr_rdata, 32'h11111111 * (k + 1));
    end
    chk("cnt", o_count_reg, 32'h22222222);
    chk("src", o_source_index_reg, 32'h77777777);
    chk("dst", o_dest_index_reg, 32'h88888888);
  endtask
  initial
  begin
    t_reset;
    t_real;
    t_smm_ctrl;
    t_prot;
    t_smm_pin;
    t_gpr;
    t_reset;
    report_and_stop;
  end
endmodule // emac_mode_ctrl_tb
